// [logic/ebt_timer.sv]
// Purpose: 8-bit timer/counter with two compares and three irq flags.
// Assumes: One 200 MHz clock; Avalon-MM slave, one word per register.
// Notes: Selected timer clock acts as a count enable on i_ref_clk.
// Overview of operation
// - Control bits 7:4 read zero, ignored
// - Mask and flag bits 7:3 read zero
// - Bit 3: free-run or clear on A
// - Wrap flag set on 0xff to zero
// - Clock select: stop, taps, pin edges
// - Pin edges count even when pin outputs
// - Counter readable and writable by software
// - Counter write blocks next timer-clock match
// - Compare A matches raise channel A event
// - Compare B matches raise channel B event
// - Request B when enable, global, flag set
// - Request A when enable, global, flag set
// - Wrap request when enable, global, flag set
// - Flag B set on match, vector/W1C clears
// - Flag A set on match, vector/W1C clears
// - Wrap flag cleared by vector or W1C
// - Counter write beats increment and clear
// - Match flag set one timer clock later
// - Clear mode: zero after matching A
//
// The Avalon-MM slave port and the address map were decided locally.
`include "ebt_defs.svh"

module ebt_timer (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic [2:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic i_external_count_pin,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [2:0] o_irq_req
);
    ebt_pkg::ebt_bus_req_t bus;
    logic [3:0] ctrl_reg;
    logic [7:0] count_reg, count_next;
    logic [7:0] cmpa_reg, cmpb_reg;
    ebt_pkg::ebt_irq_bits_t mask_reg, flags_reg, flags_next;
    logic gie_reg;
    logic [`EBT_PS_W-1:0] ps_reg;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic block_reg, block_next;
    logic ack_reg;
    // Waitrequest keeps its own flop so the bus pin sees no gate
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [2:0] irq_reg;

    assign bus = '{read: i_avs_read, write: i_avs_write,
                   address: i_avs_address, writedata: i_avs_writedata};

    // One wait cycle per access: answer at the edge after ack_reg rises
    wire req = bus.read | bus.write;
    wire take = req & ack_reg;
    wire lane0 = i_avs_byteenable[0];
    wire wr = take & bus.write & lane0;
    wire wr_ctrl = wr & (bus.address == `EBT_OFS_CTRL);
    wire wr_count = wr & (bus.address == `EBT_OFS_COUNT);
    wire wr_cmpa = wr & (bus.address == `EBT_OFS_CMPA);
    wire wr_cmpb = wr & (bus.address == `EBT_OFS_CMPB);
    wire wr_mask = wr & (bus.address == `EBT_OFS_MASK);
    wire wr_flags = wr & (bus.address == `EBT_OFS_FLAGS);
    wire wr_gie = wr & (bus.address == `EBT_OFS_GIE);
    wire wr_vack = wr & (bus.address == `EBT_OFS_VECACK);
    wire [7:0] wbyte = bus.writedata[7:0];

    wire mode_clear = ctrl_reg[`EBT_CTRL_MODE_BIT];
    wire [2:0] clk_sel = ctrl_reg[`EBT_CS_MSB:0];

    // Prescaler taps pulse when the low bits of the free counter wrap
    wire [`EBT_PS_W-1:0] ps_plus = ps_reg + 1'b1;
    wire tap8 = (ps_reg[2:0] == 3'h7);
    wire tap64 = (ps_reg[5:0] == 6'h3f);
    wire tap256 = (ps_reg[7:0] == 8'hff);
    wire tap1024 = (ps_reg == 10'h3ff);

    // Pin is sampled regardless of its direction elsewhere in the chip
    wire pin_rise = pin_sync_reg & ~pin_prev_reg;
    wire pin_fall = ~pin_sync_reg & pin_prev_reg;

    logic tick;
    always_comb
    begin
        case (ebt_pkg::ebt_clk_sel_t'(clk_sel))
            ebt_pkg::EBT_CS_STOP: tick = 1'b0;
            ebt_pkg::EBT_CS_DIV1: tick = 1'b1;
            ebt_pkg::EBT_CS_DIV8: tick = tap8;
            ebt_pkg::EBT_CS_DIV64: tick = tap64;
            ebt_pkg::EBT_CS_DIV256: tick = tap256;
            ebt_pkg::EBT_CS_DIV1024: tick = tap1024;
            ebt_pkg::EBT_CS_PIN_FALL: tick = pin_fall;
            ebt_pkg::EBT_CS_PIN_RISE: tick = pin_rise;
            default: tick = 1'b0;
        endcase
    end

    wire eq_a = (count_reg == cmpa_reg);
    wire eq_b = (count_reg == cmpb_reg);
    // Matches land on the timer clock after equality, unless blocked
    wire hit_a = tick & eq_a & ~block_reg;
    wire hit_b = tick & eq_b & ~block_reg;
    wire clr_on_a = mode_clear & eq_a;
    // A clear from a top of 0xff still passes MAX, so it flags as well
    wire wrap = tick & (count_reg == `EBT_TOP_FREE);

    always_comb
    begin
        count_next = count_reg;
        if (wr_count)
            count_next = wbyte;
        else if (tick & clr_on_a)
            count_next = `EBT_RST_BYTE;
        else if (tick)
            count_next = count_reg + 8'h01;
    end

    // Blocking lasts until the next timer clock, even if stopped
    always_comb
    begin
        block_next = block_reg;
        if (wr_count)
            block_next = 1'b1;
        else if (tick)
            block_next = 1'b0;
    end

    // Set wins over a same-cycle clear; zero writes do nothing
    wire [2:0] w1c = wr_flags ? wbyte[2:0] : 3'h0;
    wire [2:0] vclr = wr_vack ? wbyte[2:0] : 3'h0;
    wire [2:0] hw_set = {hit_b, hit_a, wrap};
    assign flags_next = (flags_reg & ~(w1c | vclr)) | hw_set;

    wire [2:0] pend = flags_reg & mask_reg & {3{gie_reg}};

    logic [31:0] rd_mux;
    always_comb
    begin
        case (bus.address)
            `EBT_OFS_CTRL: rd_mux = {28'h0, ctrl_reg};
            `EBT_OFS_COUNT: rd_mux = {24'h0, count_reg};
            `EBT_OFS_CMPA: rd_mux = {24'h0, cmpa_reg};
            `EBT_OFS_CMPB: rd_mux = {24'h0, cmpb_reg};
            `EBT_OFS_MASK: rd_mux = {29'h0, mask_reg};
            `EBT_OFS_FLAGS: rd_mux = {29'h0, flags_reg};
            `EBT_OFS_GIE: rd_mux = {31'h0, gie_reg};
            default: rd_mux = `EBT_UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ack_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= req & ~ack_reg;
            wait_reg <= ~(req & ~ack_reg);
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_reg <= 4'h0;
            cmpa_reg <= `EBT_RST_BYTE;
            cmpb_reg <= `EBT_RST_BYTE;
            mask_reg <= 3'h0;
            gie_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= wbyte[3:0];
            if (wr_cmpa)
                cmpa_reg <= wbyte;
            if (wr_cmpb)
                cmpb_reg <= wbyte;
            if (wr_mask)
                mask_reg <= wbyte[2:0];
            if (wr_gie)
                gie_reg <= wbyte[0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            count_reg <= `EBT_RST_BYTE;
            block_reg <= 1'b0;
            flags_reg <= 3'h0;
            irq_reg <= 3'h0;
            ps_reg <= '0;
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            block_reg <= block_next;
            flags_reg <= flags_next;
            irq_reg <= pend;
            ps_reg <= ps_plus;
            pin_meta_reg <= i_external_count_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_irq_req = irq_reg;

    a_wrap_sets_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (tick && !wr_count && !clr_on_a && count_reg == 8'hff)
        |=> (flags_reg[0] && count_reg == 8'h00))
        else $error("wrap did not set flag or zero counter");

    a_clear_on_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (tick && !wr_count && mode_clear && eq_a) |=> count_reg == 8'h00)
        else $error("clear mode did not zero counter");

    a_write_priority: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        wr_count |=> count_reg == $past(wbyte))
        else $error("counter write lost");

    a_block_match: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (block_reg && tick && !(wr_flags && wbyte[1]) && !wr_vack
            && !flags_reg[1]) |=> !flags_reg[1])
        else $error("blocked match set flag A");

    a_match_b_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (tick && eq_b && !block_reg) |=> flags_reg[2])
        else $error("match B flag not set");

    a_w1c_clears: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr_flags && wbyte[1] && !hit_a) |=> !flags_reg[1])
        else $error("flag A not cleared by one");

    a_zero_keeps: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr_flags && !wbyte[0] && flags_reg[0]) |=> flags_reg[0])
        else $error("zero write cleared wrap flag");

    a_irq_gate: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        o_irq_req[0] == $past(flags_reg[0] & mask_reg[0] & gie_reg))
        else $error("wrap request mismatch");

    a_stop_holds: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (clk_sel == 3'h0 && !wr_count) |=> $stable(count_reg))
        else $error("stopped counter moved");

    a_rsvd_zero: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (take && bus.read && bus.address == 3'h5)
        |-> o_avs_readdata[31:3] == 29'h0)
        else $error("reserved flag bits nonzero");

    a_top_wrap_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (tick && count_reg == 8'hff) |=> flags_reg[0])
        else $error("leaving 0xff did not set wrap flag");

    a_match_a_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (tick && eq_a && !block_reg) |=> flags_reg[1])
        else $error("match A flag not set");

    a_block_match_b: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (block_reg && tick && !flags_reg[2]) |=> !flags_reg[2])
        else $error("blocked match set flag B");

    a_w1c_wrap: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr_flags && wbyte[0] && !wrap) |=> !flags_reg[0])
        else $error("wrap flag not cleared by one");

    a_vector_wrap: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr_vack && wbyte[0] && !wrap) |=> !flags_reg[0])
        else $error("wrap flag not cleared by vector");

    a_w1c_match_b: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr_flags && wbyte[2] && !hit_b) |=> !flags_reg[2])
        else $error("flag B not cleared by one");

    a_irq_a_gate: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        o_irq_req[1] == $past(flags_reg[1] & mask_reg[1] & gie_reg))
        else $error("match A request mismatch");

    a_irq_b_gate: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        o_irq_req[2] == $past(flags_reg[2] & mask_reg[2] & gie_reg))
        else $error("match B request mismatch");

    a_gie_blocks_irq: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        !gie_reg |=> o_irq_req == 3'h0)
        else $error("request raised with global enable off");

    a_rsvd_ctrl: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (take && bus.read && bus.address == 3'h0)
        |-> o_avs_readdata[31:4] == 28'h0)
        else $error("reserved control bits nonzero");

    a_rsvd_mask: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (take && bus.read && bus.address == 3'h4)
        |-> o_avs_readdata[31:3] == 29'h0)
        else $error("reserved mask bits nonzero");

    a_pin_rise_step: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (clk_sel == 3'h7 && pin_rise && !wr_count && !clr_on_a)
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("rising pin edge did not count");

    a_pin_fall_step: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (clk_sel == 3'h6 && pin_fall && !wr_count && !clr_on_a)
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("falling pin edge did not count");

    a_cmpb_write: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        wr_cmpb |=> cmpb_reg == $past(wbyte))
        else $error("compare B write lost");

    a_wait_one: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("access not answered after one wait cycle");

    a_wait_stands: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule

// [logic/ebt_defs.svh]
// Purpose: Offsets, field positions and reset values of the 8-bit timer.
// Assumes: Avalon-MM word addressing, 32-bit data, 8-bit registers.
// Notes: Included by the timer module only; the package does not include it.
`ifndef EBT_DEFS_SVH
`define EBT_DEFS_SVH

`define EBT_ADDR_W 3
`define EBT_OFS_CTRL 3'h0
`define EBT_OFS_COUNT 3'h1
`define EBT_OFS_CMPA 3'h2
`define EBT_OFS_CMPB 3'h3
`define EBT_OFS_MASK 3'h4
`define EBT_OFS_FLAGS 3'h5
`define EBT_OFS_GIE 3'h6
`define EBT_OFS_VECACK 3'h7

`define EBT_CTRL_MODE_BIT 3
`define EBT_CS_MSB 2
`define EBT_BIT_MATCH_B 2
`define EBT_BIT_MATCH_A 1
`define EBT_BIT_WRAP 0

`define EBT_RST_BYTE 8'h00
`define EBT_TOP_FREE 8'hff
`define EBT_PS_W 10
`define EBT_UNMAPPED_DATA 32'h0000_0000

`endif

// [logic/ebt_pkg.sv]
// Purpose: Types shared by the 8-bit timer.
// Assumes: Values are literals here; ebt_defs.svh is not included.
// Notes: Nothing here is imported; users write ebt_pkg::name.
package ebt_pkg;
    typedef enum logic [2:0] {
        EBT_CS_STOP = 3'h0,
        EBT_CS_DIV1 = 3'h1,
        EBT_CS_DIV8 = 3'h2,
        EBT_CS_DIV64 = 3'h3,
        EBT_CS_DIV256 = 3'h4,
        EBT_CS_DIV1024 = 3'h5,
        EBT_CS_PIN_FALL = 3'h6,
        EBT_CS_PIN_RISE = 3'h7
    } ebt_clk_sel_t;

    typedef struct packed {
        logic match_b;
        logic match_a;
        logic wrap;
    } ebt_irq_bits_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [2:0] address;
        logic [31:0] writedata;
    } ebt_bus_req_t;
endpackage

// [verif/tb_eight_bit_timer_registers.sv]
// Purpose: Self-checking bench for the 8-bit timer register block.
// Assumes: Avalon-MM slave with one wait cycle, 200 MHz reference clock.
// Notes: Count windows allow one tick of slack for the free prescaler phase.
module tb_eight_bit_timer_registers;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic wr;
        logic [2:0] a;
        logic [7:0] d;
        logic [3:0] be;
        logic [7:0] exp;
    } ebt_row_t;
    logic i_ref_clk, i_arst_n, i_avs_read, i_avs_write, pin;
    logic [2:0] i_avs_address, o_irq_req;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0] i_avs_byteenable;
    logic o_avs_waitrequest;
    logic [7:0] q;
    int err_count = 0;
    int checks_done = 0;
    int n;
    int divs [4] = '{8, 64, 256, 1024};
    ebt_row_t rows [13] = '{
        '{1, 0, 8'hf0, 4'hf, 8'h00}, '{0, 0, 8'h00, 4'hf, 8'h00},
        '{1, 4, 8'hff, 4'hf, 8'h00}, '{0, 4, 8'h00, 4'hf, 8'h07},
        '{1, 5, 8'hff, 4'hf, 8'h00}, '{0, 5, 8'h00, 4'hf, 8'h00},
        '{1, 2, 8'ha5, 4'hf, 8'h00}, '{0, 2, 8'h00, 4'hf, 8'ha5},
        '{1, 3, 8'h5a, 4'hf, 8'h00}, '{0, 3, 8'h00, 4'hf, 8'h5a},
        '{1, 1, 8'h3c, 4'hf, 8'h00}, '{1, 1, 8'h77, 4'he, 8'h00},
        '{0, 1, 8'h00, 4'hf, 8'h3c}};

    ebt_timer dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .i_external_count_pin(pin),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_irq_req(o_irq_req));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, g);
        chk8(nm, {7'h0, e}, {7'h0, g});
    endtask

    // Request held until the edge where waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        @(posedge i_ref_clk);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_byteenable <= be;
        do
        begin
            @(posedge i_ref_clk);
            k++;
        end while (o_avs_waitrequest !== 1'b0 && k < 64);
        chk1("waitrequest", 1'b0, o_avs_waitrequest);
        q = o_avs_readdata[7:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [2:0] a);
        bus(1'b0, a, 8'h00, 4'hf);
    endtask

    task automatic wait_irq(input int b);
        n = 0;
        while (o_irq_req[b] !== 1'b1 && n < 400)
        begin
            @(posedge i_ref_clk);
            n++;
        end
        wr(0, 8'h00);
    endtask

    task automatic all_zero();
        for (int a = 0; a < 8; a++)
        begin
            rd(a[2:0]);
            chk8("reset value", 8'h00, q);
        end
    endtask

    initial
    begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    initial
    begin
        repeat (90000) @(posedge i_ref_clk);
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        wrap_up();
    end

    initial
    begin
        {i_arst_n, i_avs_read, i_avs_write, pin} = '0;
        {i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
        repeat (10) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        all_zero();
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].be);
            if (!rows[i].wr)
                chk8("register row", rows[i].exp, q);
        end
        $display("test registers done");
        // Overflow from 0xff to zero, then write-one-to-clear
        wr(1, 8'hf0); wr(6, 8'h01); wr(4, 8'h01); wr(0, 8'h01);
        wait_irq(0);
        chk8("wrap irq", 8'h01, {5'h0, o_irq_req});
        rd(5);
        chk8("wrap flag", 8'h01, q);
        wr(5, 8'h06);
        rd(5);
        chk8("zero write", 8'h01, q);
        wr(4, 8'h00);
        repeat (2) @(posedge i_ref_clk);
        chk8("masked irq", 8'h00, {5'h0, o_irq_req});
        wr(5, 8'h01);
        rd(5);
        chk8("wrap clear", 8'h00, q);
        $display("test overflow done");
        // Counter write equal to compare B must not flag at next tick
        wr(3, 8'h10); wr(4, 8'h04); wr(1, 8'h10); wr(0, 8'h01); wr(0, 8'h00);
        rd(5);
        chk8("blocked match", 8'h00, q);
        wr(1, 8'h0e); wr(0, 8'h01);
        wait_irq(2);
        chk8("match b irq", 8'h04, {5'h0, o_irq_req});
        rd(5);
        chk8("match b flag", 8'h04, q);
        wr(7, 8'h04);
        rd(5);
        chk8("vector clear", 8'h00, q);
        $display("test compare b done");
        // Clear-on-compare with top of 5: never passes 5, no overflow
        wr(2, 8'h05); wr(1, 8'h00); wr(4, 8'h02); wr(0, 8'h09);
        repeat (300) @(posedge i_ref_clk);
        chk8("match a irq", 8'h02, {5'h0, o_irq_req});
        wr(0, 8'h00);
        rd(1);
        chk1("clear mode bound", 1'b1, q <= 8'h05);
        rd(5);
        chk8("clear mode flags", 8'h02, q);
        wr(5, 8'h07);
        $display("test clear mode done");
        foreach (divs[k])
        begin
            wr(1, 8'h00);
            wr(0, 8'(k + 2));
            repeat (divs[k] * 20) @(posedge i_ref_clk);
            wr(0, 8'h00);
            rd(1);
            chk1("prescaled count", 1'b1, q >= 19 && q <= 21);
        end
        $display("test prescaler done");
        for (int m = 7; m >= 6; m--)
        begin
            wr(1, 8'h00);
            wr(0, 8'(m));
            repeat (10)
            begin
                @(posedge i_ref_clk) pin <= ~pin;
                repeat (4) @(posedge i_ref_clk);
            end
            repeat (6) @(posedge i_ref_clk);
            wr(0, 8'h00);
            rd(1);
            chk8("pin edge count", 8'h05, q);
        end
        $display("test pin done");
        wr(1, 8'h40); wr(0, 8'h01);
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk1("reset wait", 1'b1, o_avs_waitrequest);
        i_arst_n <= 1'b1;
        all_zero();
        $display("test reset done");
        wrap_up();
    end
endmodule
